// ==== rtl/usb_node_config_regs.sv ====
/*
  Configuration register bank of the USB node: identification, header
  mode and lock, node number, oscillator frequency and link control.
  Assumes single-cycle configuration accesses on CLK_SYS_I from the
  switch network, and a link engine that reports status as pins.
*/
`timescale 1ns/1ns
`default_nettype none
`include "usb_node_cfg_defs.svh"
// Functional notes
// (RULE_01) read-only id word: chip id top byte, revision 15:8, version low byte
// (RULE_02) lock bit set blocks later writes to node and link registers
// (RULE_03) header mode bit: 0 three-byte headers, 1 one-byte headers, reset 0
// (RULE_04) writable 16-bit node number, reset zero, compatibility only
// (RULE_05) seven-bit oscillator MHz field, resets to 25
// (RULE_06) only 5..100 accepted; others leave field and get nack
// (RULE_07) configurer programs frequency at start-up and on oscillator change
// (RULE_08) read-only bit flags rx overflow or illegal token received
// (RULE_09) read-only credit issued and credit held bits, zero after reset
// (RULE_10) writing restart bit clears local credit, sends credit request token
// (RULE_11) writing receiver reset bit restarts token framing in receiver
// (RULE_12) symbol gap field 21:11, reset 1, stored as minimum minus one
// (RULE_13) token gap field 10:0, reset 1, stored as minimum minus one
// (RULE_14) reserved bits read zero, writes to them ignored
module usb_node_config_regs
  import usb_node_cfg_pkg::*;
#(
  parameter logic [7:0] CHIP_ID  = 8'h5A, // arbitrary value
  parameter logic [7:0] BLK_REV  = 8'h01, // arbitrary value
  parameter logic [7:0] BLK_VER  = 8'h01  // arbitrary value
) (
  input  wire logic                       CLK_SYS_I,
  input  wire logic                       RESET_N_I,
  input  wire logic                       CFG_WR_I,
  input  wire logic                       CFG_RD_I,
  input  wire usb_node_cfg_pkg::reg_num_t CFG_NUM_I,
  input  wire usb_node_cfg_pkg::word_t    CFG_WDATA_I,
  output usb_node_cfg_pkg::word_t         CFG_RDATA_O,
  output logic                            CFG_ACK_O,
  output logic                            CFG_NACK_O,
  input  wire logic                       LINK_RX_ERR_I,
  input  wire logic                       LINK_CREDIT_ISSUED_I,
  input  wire logic                       LINK_CREDIT_HELD_I,
  output logic                            LINK_CREDIT_CLEAR_O,
  output logic                            LINK_CREDIT_REQUEST_TOKEN_O,
  output logic                            LINK_RX_RESET_O,
  output logic                            HDR_ONE_BYTE_O,
  output logic      [`OSC_MHZ_W-1:0]      OSC_MHZ_O,
  output usb_node_cfg_pkg::gap_t          SYM_GAP_O,
  output usb_node_cfg_pkg::gap_t          TOK_GAP_O
);
  import usb_node_cfg_pkg::*;

  logic                      lock_q;
  logic                      hdr_q;
  logic [`NODE_NUMBER_W-1:0] node_num_q;
  logic [`OSC_MHZ_W-1:0]     osc_q;
  logic                      rx_err_s;
  logic                      issued_s;
  logic                      held_s;
  logic                      wr_node;
  logic                      wr_num;
  logic                      wr_osc;
  logic                      wr_link;
  logic                      osc_ok;
  logic                      known;
  logic [`OSC_MHZ_W-1:0]     osc_w;
  word_t                     rdata_d;

  // decode, range check and per-register read images
  logic                      hit_id;
  logic                      hit_node;
  logic                      hit_num;
  logic                      hit_osc;
  logic                      hit_link;
  logic                      osc_hi_zero;
  logic                      osc_ge_min;
  logic                      osc_le_max;
  logic                      wr_bad_osc;
  logic                      restart_req;
  logic                      rxrst_req;

  word_t                     id_word;
  word_t                     node_word;
  word_t                     num_word;
  word_t                     osc_word;
  word_t                     link_word;

  // link status arrives from the link engine's clock region
  cfg_sync2 u_sync_err (
    .clk_i     (CLK_SYS_I),
    .reset_n_i (RESET_N_I),
    .async_i   (LINK_RX_ERR_I),
    .sync_o    (rx_err_s)
  );
  cfg_sync2 u_sync_issued (
    .clk_i     (CLK_SYS_I),
    .reset_n_i (RESET_N_I),
    .async_i   (LINK_CREDIT_ISSUED_I),
    .sync_o    (issued_s)
  );
  cfg_sync2 u_sync_held (
    .clk_i     (CLK_SYS_I),
    .reset_n_i (RESET_N_I),
    .async_i   (LINK_CREDIT_HELD_I),
    .sync_o    (held_s)
  );

  // one select per register number
  assign hit_id   = (CFG_NUM_I == `REG_BLOCK_IDENTIFICATION);
  assign hit_node = (CFG_NUM_I == `REG_NODE_HEADER_AND_LOCK);
  assign hit_num  = (CFG_NUM_I == `REG_NODE_NUMBER);
  assign hit_osc  = (CFG_NUM_I == `REG_OSCILLATOR_MEGAHERTZ);
  assign hit_link = (CFG_NUM_I == `REG_LINK_CREDIT_PACING);
  assign known    = hit_id || hit_node || hit_num || hit_osc || hit_link;

  assign osc_w       = CFG_WDATA_I[`OSC_MHZ_W-1:0];
  // upper bits must be zero too, else a wide value aliases into range
  assign osc_hi_zero = (CFG_WDATA_I[31:`OSC_MHZ_W] == 25'h000_0000); // RULE_06
  assign osc_ge_min  = (osc_w >= `OSC_MHZ_MIN); // RULE_06
  assign osc_le_max  = (osc_w <= `OSC_MHZ_MAX); // RULE_06
  assign osc_ok      = osc_hi_zero && osc_ge_min && osc_le_max;
  assign wr_bad_osc  = CFG_WR_I && hit_osc && !osc_ok; // RULE_06

  // lock gates only the node and link registers; number and frequency stay open
  assign wr_node     = CFG_WR_I && !lock_q && hit_node; // RULE_02
  assign wr_link     = CFG_WR_I && !lock_q && hit_link; // RULE_02
  assign wr_num      = CFG_WR_I && hit_num;
  assign wr_osc      = CFG_WR_I && hit_osc && osc_ok; // RULE_06
  assign restart_req = wr_link && CFG_WDATA_I[`LINK_RESTART_BIT]; // RULE_10
  assign rxrst_req   = wr_link && CFG_WDATA_I[`LINK_RXRST_BIT]; // RULE_11

  // lock clears only through reset
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      lock_q <= 1'b0;
    end else if (wr_node) begin
      lock_q <= CFG_WDATA_I[`NODE_LOCK_BIT]; // RULE_02
    end
  end

  // header mode follows the same write that may set the lock
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      hdr_q <= 1'b0; // RULE_03
    end else if (wr_node) begin
      hdr_q <= CFG_WDATA_I[`NODE_HDR_MODE_BIT]; // RULE_03
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      node_num_q <= 16'h0000;
    end else if (wr_num) begin
      node_num_q <= CFG_WDATA_I[`NODE_NUMBER_W-1:0]; // RULE_04
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      osc_q <= `OSC_MHZ_RESET; // RULE_05
    end else if (wr_osc) begin
      osc_q <= osc_w; // RULE_05
    end
  end

  cfg_gap_field u_sym_gap (
    .clk_i     (CLK_SYS_I),
    .reset_n_i (RESET_N_I),
    .wr_i      (wr_link),
    .wdata_i   (CFG_WDATA_I[`LINK_SYM_HI:`LINK_SYM_LO]), // RULE_12
    .gap_o     (SYM_GAP_O)
  );
  cfg_gap_field u_tok_gap (
    .clk_i     (CLK_SYS_I),
    .reset_n_i (RESET_N_I),
    .wr_i      (wr_link),
    .wdata_i   (CFG_WDATA_I[`LINK_TOK_HI:`LINK_TOK_LO]), // RULE_13
    .gap_o     (TOK_GAP_O)
  );

  // write-only actions: one-cycle pulses, the bits never store
  // clear and token share one decode so they can never split
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      LINK_CREDIT_CLEAR_O <= 1'b0;
    end else begin
      LINK_CREDIT_CLEAR_O <= restart_req; // RULE_10
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      LINK_CREDIT_REQUEST_TOKEN_O <= 1'b0;
    end else begin
      LINK_CREDIT_REQUEST_TOKEN_O <= restart_req; // RULE_10
    end
  end

  // receiver reset restarts token framing at the far engine
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      LINK_RX_RESET_O <= 1'b0;
    end else begin
      LINK_RX_RESET_O <= rxrst_req; // RULE_11
    end
  end

  // each register's read image; reserved bits stay zero
  always_comb begin
    id_word                          = 32'h0000_0000; // RULE_14
    id_word[`ID_CHIP_HI:`ID_CHIP_LO] = CHIP_ID; // RULE_01
    id_word[`ID_REV_HI:`ID_REV_LO]   = BLK_REV; // RULE_01
    id_word[`ID_VER_HI:`ID_VER_LO]   = BLK_VER; // RULE_01
  end

  always_comb begin
    node_word                     = 32'h0000_0000; // RULE_14
    node_word[`NODE_LOCK_BIT]     = lock_q; // RULE_02
    node_word[`NODE_HDR_MODE_BIT] = hdr_q; // RULE_03
  end

  always_comb begin
    num_word                     = 32'h0000_0000; // RULE_14
    num_word[`NODE_NUMBER_W-1:0] = node_num_q; // RULE_04
  end

  // reads back the last accepted value
  always_comb begin
    osc_word                 = 32'h0000_0000; // RULE_14
    osc_word[`OSC_MHZ_W-1:0] = osc_q; // RULE_05
  end

  // status bits are plain synced levels, not sticky
  always_comb begin
    link_word                            = 32'h0000_0000; // RULE_14
    link_word[`LINK_ERR_BIT]             = rx_err_s; // RULE_08
    link_word[`LINK_ISSUED_BIT]          = issued_s; // RULE_09
    link_word[`LINK_HOLDS_BIT]           = held_s; // RULE_09
    link_word[`LINK_SYM_HI:`LINK_SYM_LO] = SYM_GAP_O; // RULE_12
    link_word[`LINK_TOK_HI:`LINK_TOK_LO] = TOK_GAP_O; // RULE_13
  end

  // unmapped numbers read zero; the answer path refuses them
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (CFG_NUM_I)
      `REG_BLOCK_IDENTIFICATION: begin
        rdata_d = id_word;
      end
      `REG_NODE_HEADER_AND_LOCK: begin
        rdata_d = node_word;
      end
      `REG_NODE_NUMBER: begin
        rdata_d = num_word;
      end
      `REG_OSCILLATOR_MEGAHERTZ: begin
        rdata_d = osc_word;
      end
      `REG_LINK_CREDIT_PACING: begin
        rdata_d = link_word;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // read data registered; idle cycles show zero so no stale word leaks
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      CFG_RDATA_O <= 32'h0000_0000;
    end else if (CFG_RD_I) begin
      CFG_RDATA_O <= rdata_d; // RULE_14
    end else begin
      CFG_RDATA_O <= 32'h0000_0000;
    end
  end

  // locked writes are acked: the lock refuses, it does not fault
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      CFG_ACK_O <= 1'b0;
    end else if (CFG_WR_I) begin
      CFG_ACK_O <= known && !wr_bad_osc; // RULE_02
    end else begin
      CFG_ACK_O <= CFG_RD_I && known;
    end
  end

  // unmapped numbers and out-of-range frequency writes are refused
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      CFG_NACK_O <= 1'b0;
    end else if (CFG_WR_I) begin
      CFG_NACK_O <= !known || wr_bad_osc; // RULE_06
    end else begin
      CFG_NACK_O <= CFG_RD_I && !known;
    end
  end

  assign HDR_ONE_BYTE_O = hdr_q; // RULE_03
  assign OSC_MHZ_O      = osc_q;
endmodule
`default_nettype wire

// ==== rtl/usb_node_cfg_defs.svh ====
/*
  Register numbers, field positions, reset values and range limits
  for the node configuration register bank.
  Assumes inclusion by its bare name from the rtl sources.
*/
`ifndef USB_NODE_CFG_DEFS_SVH
`define USB_NODE_CFG_DEFS_SVH

`define REG_BLOCK_IDENTIFICATION  8'h00
`define REG_NODE_HEADER_AND_LOCK  8'h04
`define REG_NODE_NUMBER           8'h05
`define REG_OSCILLATOR_MEGAHERTZ  8'h51
`define REG_LINK_CREDIT_PACING    8'h80

`define ID_CHIP_HI     31
`define ID_CHIP_LO     24
`define ID_REV_HI      15
`define ID_REV_LO      8
`define ID_VER_HI      7
`define ID_VER_LO      0

`define NODE_LOCK_BIT      31
`define NODE_HDR_MODE_BIT  0
`define NODE_NUMBER_W      16
`define OSC_MHZ_W          7
`define OSC_MHZ_RESET      7'h19
`define OSC_MHZ_MIN        7'h05
`define OSC_MHZ_MAX        7'h64

`define LINK_ERR_BIT       27
`define LINK_ISSUED_BIT    26
`define LINK_HOLDS_BIT     25
`define LINK_RESTART_BIT   24
`define LINK_RXRST_BIT     23
`define LINK_SYM_HI        21
`define LINK_SYM_LO        11
`define LINK_TOK_HI        10
`define LINK_TOK_LO        0
`define LINK_GAP_W         11
`define LINK_GAP_RESET     11'h001

`endif

// ==== rtl/usb_node_cfg_pkg.sv ====
/*
  Types shared by the node configuration register bank.
  Assumes usb_node_cfg_defs.svh supplies the numeric constants.
*/
package usb_node_cfg_pkg;
  typedef logic [7:0]  reg_num_t;
  typedef logic [31:0] word_t;
  typedef logic [10:0] gap_t;
endpackage

// ==== rtl/cfg_sync2.sv ====
/*
  Two-flop synchroniser for one level.
  Assumes the input is asynchronous to CLK_SYS_I.
*/
`timescale 1ns/1ns
`default_nettype none
module cfg_sync2 (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_q;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      meta_q <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/cfg_gap_field.sv ====
/*
  One eleven-bit idle-gap field with lock-gated write.
  Assumes write strobe and data are on the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "usb_node_cfg_defs.svh"
module cfg_gap_field (
  input  wire logic                    clk_i,
  input  wire logic                    reset_n_i,
  input  wire logic                    wr_i,
  input  wire logic [`LINK_GAP_W-1:0]  wdata_i,
  output logic      [`LINK_GAP_W-1:0]  gap_o
);
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      gap_o <= `LINK_GAP_RESET;
    end else if (wr_i) begin
      gap_o <= wdata_i;
    end
  end
endmodule
`default_nettype wire

// ==== test/usb_node_config_regs_props.sv ====
/* checker on the ports of the node configuration bank
   assumes binding onto usb_node_config_regs */
`timescale 1ns/1ns
`default_nettype none
`include "usb_node_cfg_defs.svh"
module usb_node_config_regs_props
  import usb_node_cfg_pkg::*;
#(
  parameter logic [7:0] CHIP_ID = 8'h5A,
  parameter logic [7:0] BLK_REV = 8'h01,
  parameter logic [7:0] BLK_VER = 8'h01
) (
  input wire logic                       CLK_SYS_I,
  input wire logic                       RESET_N_I,
  input wire logic                       CFG_WR_I,
  input wire logic                       CFG_RD_I,
  input wire usb_node_cfg_pkg::reg_num_t CFG_NUM_I,
  input wire usb_node_cfg_pkg::word_t    CFG_WDATA_I,
  input wire usb_node_cfg_pkg::word_t    CFG_RDATA_O,
  input wire logic                       CFG_ACK_O,
  input wire logic                       CFG_NACK_O,
  input wire logic                       LINK_CREDIT_CLEAR_O,
  input wire logic                       LINK_CREDIT_REQUEST_TOKEN_O,
  input wire logic                       LINK_RX_RESET_O,
  input wire logic                       HDR_ONE_BYTE_O,
  input wire logic [`OSC_MHZ_W-1:0]      OSC_MHZ_O,
  input wire usb_node_cfg_pkg::gap_t     SYM_GAP_O,
  input wire usb_node_cfg_pkg::gap_t     TOK_GAP_O
);
  // shadow of the lock so refused writes can be told apart
  logic  lk_q;
  word_t wd_q;
  wire logic wn = CFG_WR_I && CFG_NUM_I == `REG_NODE_HEADER_AND_LOCK && !lk_q;
  wire logic wl = CFG_WR_I && CFG_NUM_I == `REG_LINK_CREDIT_PACING && !lk_q;
  wire logic wf = CFG_WR_I && CFG_NUM_I == `REG_OSCILLATOR_MEGAHERTZ;
  wire logic ok = CFG_WDATA_I[31:7] == 25'h0 && CFG_WDATA_I[6:0] >= `OSC_MHZ_MIN
                  && CFG_WDATA_I[6:0] <= `OSC_MHZ_MAX;
  always_ff @(posedge CLK_SYS_I) begin
    wd_q <= CFG_WDATA_I;
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      lk_q <= 1'b0;
    end else if (wn && CFG_WDATA_I[31]) begin
      lk_q <= 1'b1;
    end
  end
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);
  a_one_answer: assert property ((CFG_WR_I || CFG_RD_I) |=> CFG_ACK_O != CFG_NACK_O)
    else $error("answer not single");
  a_osc_take: assert property (wf && ok |=> CFG_ACK_O && OSC_MHZ_O == wd_q[6:0])
    else $error("frequency not taken");
  a_osc_keep: assert property (wf && !ok |=> CFG_NACK_O && $stable(OSC_MHZ_O))
    else $error("bad frequency taken");
  a_gap_take: assert property (wl |=> SYM_GAP_O == wd_q[21:11]
    && TOK_GAP_O == wd_q[10:0])
    else $error("gap fields wrong");
  a_hdr_take: assert property (wn |=> HDR_ONE_BYTE_O == wd_q[0])
    else $error("header mode wrong");
  a_lock_hold: assert property (lk_q && CFG_WR_I |=> $stable(HDR_ONE_BYTE_O)
    && $stable(SYM_GAP_O) && $stable(TOK_GAP_O) && !LINK_CREDIT_CLEAR_O && !LINK_RX_RESET_O)
    else $error("locked write acted");
  a_credit_restart: assert property (wl && CFG_WDATA_I[24]
    |=> LINK_CREDIT_CLEAR_O && LINK_CREDIT_REQUEST_TOKEN_O)
    else $error("no credit restart");
  a_rx_reset: assert property (wl && CFG_WDATA_I[23] |=> LINK_RX_RESET_O)
    else $error("no receiver reset");
  a_id_word: assert property (CFG_RD_I && CFG_NUM_I == `REG_BLOCK_IDENTIFICATION
    |=> CFG_RDATA_O == {CHIP_ID, 8'h00, BLK_REV, BLK_VER})
    else $error("id word wrong");
  a_rdata_idle: assert property (!CFG_RD_I |=> CFG_RDATA_O == 32'h0000_0000)
    else $error("read data not idle");
  c_restart: cover property (wl && CFG_WDATA_I[24]);
  c_locked: cover property (lk_q && CFG_WR_I);
  c_bad_osc: cover property (wf && !ok);
endmodule
bind usb_node_config_regs usb_node_config_regs_props #(
  .CHIP_ID(CHIP_ID), .BLK_REV(BLK_REV), .BLK_VER(BLK_VER)
) i_usb_node_config_regs_props (
  .CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I), .CFG_WR_I(CFG_WR_I), .CFG_RD_I(CFG_RD_I),
  .CFG_NUM_I(CFG_NUM_I), .CFG_WDATA_I(CFG_WDATA_I), .CFG_RDATA_O(CFG_RDATA_O),
  .CFG_ACK_O(CFG_ACK_O), .CFG_NACK_O(CFG_NACK_O), .LINK_CREDIT_CLEAR_O(LINK_CREDIT_CLEAR_O),
  .LINK_CREDIT_REQUEST_TOKEN_O(LINK_CREDIT_REQUEST_TOKEN_O), .LINK_RX_RESET_O(LINK_RX_RESET_O),
  .HDR_ONE_BYTE_O(HDR_ONE_BYTE_O), .OSC_MHZ_O(OSC_MHZ_O), .SYM_GAP_O(SYM_GAP_O),
  .TOK_GAP_O(TOK_GAP_O));
`default_nettype wire

// ==== test/link_end_model.sv ====
/* far link engine: credit and error levels toward the bank
   assumes the bank's pulses arrive on the system clock */
`timescale 1ns/1ns
`default_nettype none
module link_end_model (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic grant_i,
  input  wire logic err_i,
  input  wire logic clear_i,
  input  wire logic token_i,
  input  wire logic rxrst_i,
  output logic      rx_err_o,
  output logic      issued_o,
  output logic      held_o
);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || clear_i) begin
      held_o <= 1'b0;
    end else if (grant_i) begin
      held_o <= 1'b1;
    end
  end
  // credit request answered at once: credit re-issued
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      issued_o <= 1'b0;
    end else if (token_i) begin
      issued_o <= 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || rxrst_i) begin
      rx_err_o <= 1'b0;
    end else if (err_i) begin
      rx_err_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
/* self-checking bench for the node configuration bank
   assumes the bank and link_end_model on one 25 MHz clock */
`timescale 1ns/1ns
`default_nettype none
`include "usb_node_cfg_defs.svh"
module tb;
  import usb_node_cfg_pkg::*;
  localparam logic [7:0] CID = 8'hC3; // arbitrary value
  localparam logic [7:0] REV = 8'h4E; // arbitrary value
  localparam logic [7:0] VER = 8'h71; // arbitrary value
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, grant = 1'b0, err = 1'b0;
  reg_num_t num = 8'h00;
  word_t wdata = 32'h0000_0000, rdata, cur;
  logic ack, nack, clr, tok, rxr, hdr, rx_err, issued, held;
  logic [`OSC_MHZ_W-1:0] osc;
  gap_t sym, tokg;
  int err_total = 0, n_tests = 0;
  always #20 clk = ~clk;
  usb_node_config_regs #(.CHIP_ID(CID), .BLK_REV(REV), .BLK_VER(VER)) i_usb_node_config_regs (
    .CLK_SYS_I(clk), .RESET_N_I(rst_n), .CFG_WR_I(wr), .CFG_RD_I(rd), .CFG_NUM_I(num),
    .CFG_WDATA_I(wdata), .CFG_RDATA_O(rdata), .CFG_ACK_O(ack), .CFG_NACK_O(nack),
    .LINK_RX_ERR_I(rx_err), .LINK_CREDIT_ISSUED_I(issued), .LINK_CREDIT_HELD_I(held),
    .LINK_CREDIT_CLEAR_O(clr), .LINK_CREDIT_REQUEST_TOKEN_O(tok), .LINK_RX_RESET_O(rxr),
    .HDR_ONE_BYTE_O(hdr), .OSC_MHZ_O(osc), .SYM_GAP_O(sym), .TOK_GAP_O(tokg));
  link_end_model i_link_end_model (.clk_i(clk), .rst_n_i(rst_n), .grant_i(grant), .err_i(err),
    .clear_i(clr), .token_i(tok), .rxrst_i(rxr), .rx_err_o(rx_err), .issued_o(issued),
    .held_o(held));
  task check(input word_t seen, input word_t exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // one access; answer looked at in the cycle it stands
  task acc(input logic w, input reg_num_t n, input word_t d, input logic nk);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    num <= n;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 check(word_t'({ack, nack}), word_t'({!nk, nk}));
  endtask
  task rdc(input reg_num_t n, input word_t exp, input logic nk);
    acc(1'b0, n, 32'h0000_0000, nk);
    check(rdata, exp);
  endtask
  word_t osc_tab [5] = '{32'h0000_0004, 32'h0000_0005, 32'h0000_0064,
                         32'h0000_0065, 32'h0000_0105};
  logic  bad_tab [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rdc(`REG_BLOCK_IDENTIFICATION, {CID, 8'h00, REV, VER}, 1'b0);
    rdc(`REG_NODE_HEADER_AND_LOCK, 32'h0000_0000, 1'b0);
    rdc(`REG_NODE_NUMBER, 32'h0000_0000, 1'b0);
    rdc(`REG_OSCILLATOR_MEGAHERTZ, 32'h0000_0019, 1'b0);
    rdc(`REG_LINK_CREDIT_PACING, 32'h0000_0801, 1'b0);
    acc(1'b1, `REG_NODE_NUMBER, 32'hFFFF_1234, 1'b0);
    rdc(`REG_NODE_NUMBER, 32'h0000_1234, 1'b0);
    $display("test reset and node number done");
    cur = 32'h0000_0019;
    foreach (osc_tab[i]) begin
      acc(1'b1, `REG_OSCILLATOR_MEGAHERTZ, osc_tab[i], bad_tab[i]);
      if (!bad_tab[i]) cur = osc_tab[i];
      rdc(`REG_OSCILLATOR_MEGAHERTZ, cur, 1'b0);
    end
    acc(1'b1, `REG_OSCILLATOR_MEGAHERTZ, 32'h0000_0019, 1'b0);
    check(word_t'(osc), 32'h0000_0019);
    $display("test oscillator done");
    @(posedge clk);
    grant <= 1'b1;
    err <= 1'b1;
    @(posedge clk);
    grant <= 1'b0;
    err <= 1'b0;
    repeat (4) @(posedge clk);
    rdc(`REG_LINK_CREDIT_PACING, 32'h0A00_0801, 1'b0);
    acc(1'b1, `REG_LINK_CREDIT_PACING, 32'h0189_1FFF, 1'b0);
    check(word_t'({clr, tok, rxr}), 32'h0000_0007);
    check(word_t'(sym), 32'h0000_0123);
    check(word_t'(tokg), 32'h0000_07FF);
    repeat (4) @(posedge clk);
    rdc(`REG_LINK_CREDIT_PACING, 32'h0409_1FFF, 1'b0);
    $display("test link control done");
    acc(1'b1, `REG_NODE_HEADER_AND_LOCK, 32'h8000_0001, 1'b0);
    check(word_t'(hdr), 32'h0000_0001);
    acc(1'b1, `REG_LINK_CREDIT_PACING, 32'h0180_0000, 1'b0);
    check(word_t'({clr, tok, rxr}), 32'h0000_0000);
    acc(1'b1, `REG_NODE_HEADER_AND_LOCK, 32'h0000_0000, 1'b0);
    rdc(`REG_NODE_HEADER_AND_LOCK, 32'h8000_0001, 1'b0);
    rdc(`REG_LINK_CREDIT_PACING, 32'h0409_1FFF, 1'b0);
    acc(1'b1, 8'h10, 32'hFFFF_FFFF, 1'b1);
    rdc(8'h10, 32'h0000_0000, 1'b1);
    $display("test lock and unmapped done");
    conclude;
  end
  // tests need about 76 cycles; 1000 leaves ample margin
  initial begin
    #(40 * 1000);
    err_total++;
    conclude;
  end
endmodule
`default_nettype wire
